/* src/sdp_pkg.sv */
// Purpose: constants of the single-wire debug port register set
// Assumes: 4-bit register offsets, 8-bit register data
// Notes: shared by the register block and its bench
package sdp_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [3:0] OFS_REVISION = 4'h0;
	localparam logic [3:0] OFS_ERROR = 4'h1;
	localparam logic [3:0] OFS_CTRL_PRI = 4'h2;
	localparam logic [3:0] OFS_CTRL_SEC = 4'h3;
	localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
	localparam logic [3:0] OFS_RESET_REQ = 4'h8;
	localparam logic [3:0] OFS_CLOCK_CTRL = 4'h9;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_INTER_BYTE = 7;
	localparam int BIT_PARITY_IGN = 5;
	localparam int BIT_TIMEOUT_OFF = 4;
	localparam int BIT_RESP_SUPP = 3;
	localparam int BIT_NACK_OFF = 4;
	localparam int BIT_CONT_OFF = 3;
	localparam int BIT_PORT_DIS = 2;
	localparam int BIT_KEY_UROW = 5;
	localparam int BIT_KEY_PROG = 4;
	localparam int BIT_KEY_ERASE = 3;
	// ************************************************************
	// codes and reset values
	// ************************************************************
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_PARITY = 3'h1;
	localparam logic [2:0] ERR_STOP = 3'h2;
	localparam logic [2:0] ERR_TIMEOUT = 3'h3;
	localparam logic [2:0] ERR_START = 3'h4;
	localparam logic [2:0] ERR_CONTENTION = 3'h7;
	localparam logic [2:0] GUARD_OFF = 3'h7;
	localparam logic [7:0] GUARD_MAX = 8'h80;
	localparam logic [1:0] IBD_IDLE_CHARS = 2'h2;
	localparam logic [7:0] RESET_KEY = 8'h59;
	localparam logic [1:0] CLK_SEL_16M = 2'h1;
	localparam logic [1:0] CLK_SEL_8M = 2'h2;
	localparam logic [1:0] CLK_SEL_4M = 2'h3;
	localparam logic [1:0] CLK_SEL_RESET = CLK_SEL_4M;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// response watchdog span in port clock cycles
	localparam int TIMEOUT_COUNT = 65536;
endpackage

/* src/sdp_regs.sv */
// Purpose: control and status registers of the single-wire debug port
// Assumes: reached only from the port's instruction decoder, same clock
// Notes: core_clk is the port clock; all event inputs are same-domain
// Behaviour
// - registers reachable only by debug port instructions, never by the cpu
// - offsets 0..3 physical-layer settings, 4..c access-layer registers
// - first status register bits 7:4 read the fixed port revision
// - error field 2:0 loads on port errors, a read clears it
// - error codes: 1 parity, 2 stop, 3 timeout, 4 start, 7 contention
// - inter-byte delay bit adds two idle characters between sent bytes
// - parity ignore bit suppresses parity errors
// - without timeout disable, flag timeout after 65536 cycles without response
// - response suppress bit blocks all response signatures
// - guard time code selects 128 down to 2 cycles, 7 means none
// - negative ack disable bit blocks nack on reset during load or store
// - contention disable bit stops collision and contention detection
// - writing disable clears settings and keys, drops clock request, resets port
// - key status bits 5,4,3 show user row, program and erase keys
// - program key clears when programming ends, erase key when erase ends
// - writing 59h holds system reset, any other value releases it
// - reset register reads bit 0 as held reset; port unaffected by it
// - clock select 1,2,3 give 16,8,4 mhz; 4 mhz after reset
`timescale 1ns/1ps
module sdp_regs
	import sdp_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_COUNT,
	parameter logic [3:0] PORT_REVISION = 4'h3 // arbitrary value
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic err_parity,
	input wire logic err_stop,
	input wire logic err_start,
	input wire logic err_contention,
	input wire logic access_wait,
	input wire logic sysrst_in_access,
	input wire logic key_user_row_set,
	input wire logic key_prog_set,
	input wire logic key_erase_set,
	input wire logic prog_done,
	input wire logic erase_done,
	input wire logic port_enable,
	output logic [7:0] rdata_q,
	output logic rvalid_q,
	output logic inter_byte_delay_en_q,
	output logic [1:0] idle_chars_q,
	output logic parity_ignore_q,
	output logic timeout_detect_off_q,
	output logic response_suppress_q,
	output logic [2:0] guard_time_sel_q,
	output logic [7:0] guard_cycles_q,
	output logic negative_ack_off_q,
	output logic contention_detect_off_q,
	output logic port_reset_q,
	output logic port_clk_req_q,
	output logic user_row_key_active_q,
	output logic mem_program_key_active_q,
	output logic full_erase_key_active_q,
	output logic sys_reset_q,
	output logic [1:0] port_clock_sel_q,
	output logic send_nack_q,
	output logic timeout_q
);
	// ************************************************************
	// state
	// ************************************************************
	logic [2:0] err_sig_q, err_sig_d;
	logic [16:0] tmo_cnt_q, tmo_cnt_d;
	logic [7:0] rdata_d;
	logic rvalid_d, ibd_d, par_d, tmo_off_d, rsp_d, nack_d, cont_d;
	logic [2:0] gt_d;
	logic [7:0] gtc_d;
	logic [1:0] idle_d, clk_sel_d;
	logic prst_d, on_d, key_u_d, key_p_d, key_e_d, sys_d, snack_d, tmo_d;
	logic [2:0] err_code;
	logic on, wr, rd;

	assign on = port_clk_req_q;
	// no cpu path exists; only the decoder strobes reach here
	assign wr = reg_wr && on;
	assign rd = reg_rd && on;

	// ************************************************************
	// next state
	// ************************************************************
	// one error code per cycle; contention outranks framing faults
	always_comb begin
		err_code = ERR_NONE;
		if (err_parity && !parity_ignore_q)
			err_code = ERR_PARITY;
		if (err_stop)
			err_code = ERR_STOP;
		if (timeout_q)
			err_code = ERR_TIMEOUT;
		if (err_start)
			err_code = ERR_START;
		if (err_contention && !contention_detect_off_q)
			err_code = ERR_CONTENTION;
		if (!on)
			err_code = ERR_NONE;
	end

	always_comb begin
		err_sig_d = err_sig_q;
		tmo_cnt_d = '0;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		ibd_d = inter_byte_delay_en_q;
		par_d = parity_ignore_q;
		tmo_off_d = timeout_detect_off_q;
		rsp_d = response_suppress_q;
		gt_d = guard_time_sel_q;
		nack_d = negative_ack_off_q;
		cont_d = contention_detect_off_q;
		prst_d = 1'b0;
		on_d = port_clk_req_q;
		key_u_d = user_row_key_active_q;
		key_p_d = mem_program_key_active_q;
		key_e_d = full_erase_key_active_q;
		sys_d = sys_reset_q;
		clk_sel_d = port_clock_sel_q;
		snack_d = 1'b0;
		tmo_d = 1'b0;
		// response watchdog; counter width covers the default span
		if (on && access_wait && !timeout_detect_off_q && !timeout_q) begin
			tmo_cnt_d = tmo_cnt_q + 17'h1;
			if (tmo_cnt_q == 17'(TIMEOUT_CYCLES - 1)) begin
				tmo_d = 1'b1;
				tmo_cnt_d = '0;
			end
		end
		// nack only when neither suppression applies
		if (on && sysrst_in_access && !negative_ack_off_q && !response_suppress_q)
			snack_d = 1'b1;
		// reads; unlisted offsets and reserved bits give zero
		if (rd) begin
			rvalid_d = 1'b1;
			case (reg_addr)
				OFS_REVISION: rdata_d = {PORT_REVISION, 4'h0};
				OFS_ERROR: rdata_d = {5'h0, err_sig_q};
				OFS_CTRL_PRI: rdata_d = {inter_byte_delay_en_q, 1'b0, parity_ignore_q,
					timeout_detect_off_q, response_suppress_q, guard_time_sel_q};
				OFS_CTRL_SEC: rdata_d = {3'h0, negative_ack_off_q,
					contention_detect_off_q, 3'h0};
				OFS_KEY_STATUS: rdata_d = {2'h0, user_row_key_active_q,
					mem_program_key_active_q, full_erase_key_active_q, 3'h0};
				OFS_RESET_REQ: rdata_d = {7'h0, sys_reset_q};
				OFS_CLOCK_CTRL: rdata_d = {6'h0, port_clock_sel_q};
				default: rdata_d = 8'h00;
			endcase
			if (reg_addr == OFS_ERROR)
				err_sig_d = ERR_NONE;
		end
		// a fresh error beats the read clear in the same cycle
		if (err_code != ERR_NONE)
			err_sig_d = err_code;
		// writes to physical-layer and access-layer registers
		if (wr) begin
			case (reg_addr)
				OFS_CTRL_PRI: begin
					ibd_d = reg_wdata[BIT_INTER_BYTE];
					par_d = reg_wdata[BIT_PARITY_IGN];
					tmo_off_d = reg_wdata[BIT_TIMEOUT_OFF];
					rsp_d = reg_wdata[BIT_RESP_SUPP];
					gt_d = reg_wdata[2:0];
				end
				OFS_CTRL_SEC: begin
					nack_d = reg_wdata[BIT_NACK_OFF];
					cont_d = reg_wdata[BIT_CONT_OFF];
				end
				OFS_RESET_REQ: sys_d = (reg_wdata == RESET_KEY);
				OFS_CLOCK_CTRL: clk_sel_d = reg_wdata[1:0];
				default: ;
			endcase
		end
		// keys: a set in the same cycle as its end event wins
		if (prog_done)
			key_p_d = 1'b0;
		if (erase_done)
			key_e_d = 1'b0;
		if (on && key_user_row_set)
			key_u_d = 1'b1;
		if (on && key_prog_set)
			key_p_d = 1'b1;
		if (on && key_erase_set)
			key_e_d = 1'b1;
		// disable wipes everything, including a held system reset
		if (wr && reg_addr == OFS_CTRL_SEC && reg_wdata[BIT_PORT_DIS]) begin
			{ibd_d, par_d, tmo_off_d, rsp_d, nack_d, cont_d} = '0;
			gt_d = CTRL_RESET[2:0];
			{key_u_d, key_p_d, key_e_d, sys_d} = '0;
			err_sig_d = ERR_NONE;
			tmo_cnt_d = '0;
			clk_sel_d = CLK_SEL_RESET;
			on_d = 1'b0;
			prst_d = 1'b1;
			snack_d = 1'b0;
		end else if (!on && port_enable) begin
			on_d = 1'b1;
			clk_sel_d = CLK_SEL_RESET;
		end
		// derived link timing
		gtc_d = (gt_d == GUARD_OFF) ? 8'h00 : (GUARD_MAX >> gt_d);
		idle_d = ibd_d ? IBD_IDLE_CHARS : 2'h0;
	end

	// ************************************************************
	// registers
	// ************************************************************
	// system reset output never loops back into srst of this block
	always_ff @(posedge core_clk) begin
		if (srst) begin
			err_sig_q <= ERR_NONE;
			tmo_cnt_q <= '0;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			{inter_byte_delay_en_q, parity_ignore_q, timeout_detect_off_q} <= '0;
			{response_suppress_q, negative_ack_off_q, contention_detect_off_q} <= '0;
			guard_time_sel_q <= CTRL_RESET[2:0];
			guard_cycles_q <= GUARD_MAX;
			idle_chars_q <= 2'h0;
			port_reset_q <= 1'b0;
			port_clk_req_q <= 1'b1;
			{user_row_key_active_q, mem_program_key_active_q} <= '0;
			full_erase_key_active_q <= 1'b0;
			sys_reset_q <= 1'b0;
			port_clock_sel_q <= CLK_SEL_RESET;
			send_nack_q <= 1'b0;
			timeout_q <= 1'b0;
		end else if (ce) begin
			err_sig_q <= err_sig_d;
			tmo_cnt_q <= tmo_cnt_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			{inter_byte_delay_en_q, parity_ignore_q, timeout_detect_off_q} <=
				{ibd_d, par_d, tmo_off_d};
			{response_suppress_q, negative_ack_off_q, contention_detect_off_q} <=
				{rsp_d, nack_d, cont_d};
			guard_time_sel_q <= gt_d;
			guard_cycles_q <= gtc_d;
			idle_chars_q <= idle_d;
			port_reset_q <= prst_d;
			port_clk_req_q <= on_d;
			{user_row_key_active_q, mem_program_key_active_q} <= {key_u_d, key_p_d};
			full_erase_key_active_q <= key_e_d;
			sys_reset_q <= sys_d;
			port_clock_sel_q <= clk_sel_d;
			send_nack_q <= snack_d;
			timeout_q <= tmo_d;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	rev_read_a: assert property (ce && rd && reg_addr == OFS_REVISION
		|=> rdata_q == {PORT_REVISION, 4'h0} && rvalid_q)
		else $error("revision read wrong");
	err_clear_a: assert property (ce && rd && reg_addr == OFS_ERROR && err_code == ERR_NONE
		|=> err_sig_q == ERR_NONE)
		else $error("error field not cleared by read");
	err_load_a: assert property (ce && err_contention && !contention_detect_off_q && on
		&& !(wr && reg_addr == OFS_CTRL_SEC && reg_wdata[BIT_PORT_DIS])
		|=> err_sig_q == ERR_CONTENTION)
		else $error("contention code not loaded");
	parity_ign_a: assert property (ce && on && parity_ignore_q && err_parity && !rd
		&& !err_stop && !err_start && !err_contention && !timeout_q
		&& !(wr && reg_addr == OFS_CTRL_SEC && reg_wdata[BIT_PORT_DIS])
		|=> err_sig_q == $past(err_sig_q))
		else $error("parity error taken while ignored");
	timeout_a: assert property (ce && on && access_wait && !timeout_detect_off_q
		&& !timeout_q && tmo_cnt_q == 17'(TIMEOUT_CYCLES - 1)
		|=> timeout_q ##1 (!$past(ce) || err_sig_q != ERR_NONE))
		else $error("timeout not flagged");
	guard_a: assert property (guard_cycles_q == ((guard_time_sel_q == GUARD_OFF) ? 8'h00
		: (GUARD_MAX >> guard_time_sel_q)))
		else $error("guard cycles mismatch");
	ibd_a: assert property (idle_chars_q == (inter_byte_delay_en_q ? IBD_IDLE_CHARS : 2'h0))
		else $error("inter-byte idle count mismatch");
	nack_a: assert property (send_nack_q
		|-> !$past(negative_ack_off_q) && !$past(response_suppress_q))
		else $error("nack sent while disabled");
	rst_req_a: assert property (ce && wr && reg_addr == OFS_RESET_REQ && !reg_wdata[BIT_PORT_DIS]
		|=> sys_reset_q == ($past(reg_wdata) == RESET_KEY))
		else $error("system reset hold wrong");
	disable_a: assert property (ce && wr && reg_addr == OFS_CTRL_SEC && reg_wdata[BIT_PORT_DIS]
		|=> port_reset_q && !port_clk_req_q && !mem_program_key_active_q
		&& !full_erase_key_active_q && guard_time_sel_q == 3'h0 && !sys_reset_q)
		else $error("disable did not clear port");
	key_end_a: assert property (ce && prog_done && !key_prog_set
		|=> !mem_program_key_active_q)
		else $error("program key not cleared");

	nack_c: cover property (send_nack_q);
	timeout_c: cover property (timeout_q);
	sysrst_c: cover property (sys_reset_q ##1 !sys_reset_q);
	disable_c: cover property (port_reset_q);
endmodule // sdp_regs

/* verif/sdp_dbg_model.sv */
// Purpose: debugger side model issuing register requests
// Assumes: strobes launched at falling edges, one cycle each
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ps
module sdp_dbg_model
	import sdp_pkg::*;
(
	input wire logic core_clk,
	input wire logic bod_high,
	input wire logic [7:0] rdata_q,
	input wire logic rvalid_q,
	output logic reg_wr,
	output logic reg_rd,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// ************************************************************
	// request tasks, the only way into the registers
	// ************************************************************
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
	end
	// one write, strobe high for exactly one rising edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge core_clk);
		// faster port clock only at the top brown-out level
		if (a == OFS_CLOCK_CTRL && !bod_high) d[1:0] = CLK_SEL_4M;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// answer is registered at the taking edge and sampled at the next falling edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output bit ok);
		@(negedge core_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		ok = (rvalid_q === 1'b1);
		d = rdata_q;
	endtask
endmodule // sdp_dbg_model

/* verif/tb.sv */
// Purpose: self-checking bench of the debug port register set
// Assumes: time-out count shortened to 16 cycles
// Notes: events launched at falling edges, results seen a cycle later
`timescale 1ns/1ps
module tb;
	import sdp_pkg::*;
	localparam logic [3:0] REV = 4'h5; // arbitrary value
	logic core_clk, srst, ce, access_wait, bod_high, reg_wr, reg_rd, rvalid_q;
	logic [10:0] ev;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, rdata_q, guard_cycles_q, d, rv;
	logic [1:0] idle_chars_q, port_clock_sel_q;
	logic [2:0] guard_time_sel_q;
	logic inter_byte_delay_en_q, parity_ignore_q, timeout_detect_off_q, response_suppress_q;
	logic negative_ack_off_q, contention_detect_off_q, port_reset_q, port_clk_req_q;
	logic user_row_key_active_q, mem_program_key_active_q, full_erase_key_active_q;
	logic sys_reset_q, send_nack_q, timeout_q;
	logic [3:0] ro[4] = '{OFS_REVISION, OFS_ERROR, OFS_KEY_STATUS, 4'h5};
	logic [3:0] zl[4] = '{OFS_CTRL_PRI, OFS_CTRL_SEC, OFS_ERROR, OFS_KEY_STATUS};
	bit ok;
	int n, failures, checked;
	sdp_regs #(.TIMEOUT_CYCLES(16), .PORT_REVISION(REV)) i_dut (
		.core_clk, .srst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.err_parity(ev[0]), .err_stop(ev[1]), .err_start(ev[2]), .err_contention(ev[3]),
		.access_wait, .sysrst_in_access(ev[4]), .key_user_row_set(ev[5]),
		.key_prog_set(ev[6]), .key_erase_set(ev[7]), .prog_done(ev[8]),
		.erase_done(ev[9]), .port_enable(ev[10]), .rdata_q, .rvalid_q,
		.inter_byte_delay_en_q, .idle_chars_q, .parity_ignore_q, .timeout_detect_off_q,
		.response_suppress_q, .guard_time_sel_q, .guard_cycles_q, .negative_ack_off_q,
		.contention_detect_off_q, .port_reset_q, .port_clk_req_q, .user_row_key_active_q,
		.mem_program_key_active_q, .full_erase_key_active_q, .sys_reset_q,
		.port_clock_sel_q, .send_nack_q, .timeout_q);
	sdp_dbg_model i_dbg (.core_clk, .bod_high, .rdata_q, .rvalid_q, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata);
	// ************************************************************
	// expectations and checking tasks
	// ************************************************************
	function automatic logic [7:0] gexp(input logic [2:0] s);
		return (s == GUARD_OFF) ? 8'h00 : GUARD_MAX >> s;
	endfunction
	function automatic logic [7:0] rst_exp(input logic [3:0] a);
		if (a == OFS_REVISION) return {REV, 4'h0};
		if (a == OFS_CLOCK_CTRL) return {6'h0, CLK_SEL_RESET};
		return 8'h00;
	endfunction
	function automatic logic [7:0] err_exp(input int i);
		case (i)
			0: return {5'h0, ERR_PARITY};
			1: return {5'h0, ERR_STOP};
			2: return {5'h0, ERR_START};
			default: return {5'h0, ERR_CONTENTION};
		endcase
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		i_dbg.rd(a, rv, ok);
		chk({7'h0, ok}, 8'h01);
		chk(rv, e);
	endtask
	// one-cycle event pulse; returns where its effect is settled
	task automatic pulse(input logic [10:0] m);
		@(negedge core_clk);
		ev = m;
		@(negedge core_clk);
		ev = 11'h000;
	endtask
	task automatic finish_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		void'($urandom(48412));
		{srst, ce, access_wait, bod_high, ev} = {4'b1100, 11'h000};
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		srst = 1'b0;
		for (int a = 0; a < 16; a++) rchk(a[3:0], rst_exp(a[3:0]));
		chk({guard_cycles_q}, GUARD_MAX);
		// read-only, clear-on-read and unmapped places ignore writes
		for (int i = 0; i < 4; i++) i_dbg.wr(ro[i], 8'hff);
		for (int i = 0; i < 4; i++) rchk(ro[i], rst_exp(ro[i]));
		$display("test reset done");
		for (int s = 0; s < 8; s++) begin
			d = 8'($urandom);
			d[2:0] = s[2:0];
			i_dbg.wr(OFS_CTRL_PRI, d);
			rchk(OFS_CTRL_PRI, d & 8'hbf);
			chk(guard_cycles_q, gexp(d[2:0]));
			chk({inter_byte_delay_en_q, 1'b0, parity_ignore_q, timeout_detect_off_q,
				response_suppress_q, guard_time_sel_q}, d & 8'hbf);
			chk({6'h0, idle_chars_q}, d[7] ? {6'h0, IBD_IDLE_CHARS} : 8'h00);
		end
		d = 8'($urandom) & 8'hfb;
		i_dbg.wr(OFS_CTRL_SEC, d);
		rchk(OFS_CTRL_SEC, d & 8'h18);
		chk({3'h0, negative_ack_off_q, contention_detect_off_q, 3'h0}, d & 8'h18);
		i_dbg.wr(OFS_CTRL_PRI, 8'h00);
		i_dbg.wr(OFS_CTRL_SEC, 8'h00);
		$display("test control done");
		// parity, stop, start and contention codes, then all four at once for the top priority
		for (int i = 0; i < 5; i++) begin
			pulse(i < 4 ? 11'(1 << i) : 11'h00f);
			rchk(OFS_ERROR, err_exp(i));
			rchk(OFS_ERROR, 8'h00);
		end
		i_dbg.wr(OFS_CTRL_PRI, 8'h20);
		pulse(11'h001);
		rchk(OFS_ERROR, 8'h00);
		i_dbg.wr(OFS_CTRL_SEC, 8'h08);
		pulse(11'h008);
		rchk(OFS_ERROR, 8'h00);
		// watchdog muted first, then live
		i_dbg.wr(OFS_CTRL_PRI, 8'h10);
		access_wait = 1'b1;
		n = 0;
		repeat (40) begin
			@(negedge core_clk);
			n += timeout_q;
		end
		chk(8'(n), 8'h00);
		i_dbg.wr(OFS_CTRL_PRI, 8'h00);
		n = 0;
		while (timeout_q !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		access_wait = 1'b0;
		if (n >= 40) begin
			failures++;
			finish_test();
		end
		chk({7'h0, n >= 15 && n <= 18}, 8'h01);
		rchk(OFS_ERROR, {5'h0, ERR_TIMEOUT});
		$display("test errors done");
		pulse(11'h0e0);
		rchk(OFS_KEY_STATUS, 8'h38);
		chk({2'h0, user_row_key_active_q, mem_program_key_active_q,
			full_erase_key_active_q, 3'h0}, 8'h38);
		pulse(11'h100);
		rchk(OFS_KEY_STATUS, 8'h28);
		pulse(11'h200);
		rchk(OFS_KEY_STATUS, 8'h20);
		$display("test keys done");
		i_dbg.wr(OFS_CTRL_PRI, 8'h05);
		i_dbg.wr(OFS_RESET_REQ, RESET_KEY);
		chk({7'h0, sys_reset_q}, 8'h01);
		rchk(OFS_RESET_REQ, 8'h01);
		rchk(OFS_CTRL_PRI, 8'h05);
		pulse(11'h010);
		chk({7'h0, send_nack_q}, 8'h01);
		do d = 8'($urandom); while (d == RESET_KEY);
		i_dbg.wr(OFS_RESET_REQ, d);
		rchk(OFS_RESET_REQ, 8'h00);
		i_dbg.wr(OFS_CTRL_SEC, 8'h10);
		pulse(11'h010);
		chk({7'h0, send_nack_q}, 8'h00);
		i_dbg.wr(OFS_CTRL_SEC, 8'h00);
		// suppression only used where bus latency is fixed
		i_dbg.wr(OFS_CTRL_PRI, 8'h08);
		pulse(11'h010);
		chk({7'h0, send_nack_q}, 8'h00);
		$display("test system reset done");
		bod_high = 1'b1;
		for (int s = 1; s < 5; s++) begin
			d = 8'($urandom);
			d[1:0] = 2'(s);
			i_dbg.wr(OFS_CLOCK_CTRL, d);
			rchk(OFS_CLOCK_CTRL, {6'h0, d[1:0]});
			chk({6'h0, port_clock_sel_q}, {6'h0, d[1:0]});
		end
		$display("test clock select done");
		// clock enable low freezes everything, events and writes alike
		ce = 1'b0;
		pulse(11'h002);
		i_dbg.wr(OFS_CTRL_PRI, 8'h07);
		ce = 1'b1;
		rchk(OFS_ERROR, 8'h00);
		rchk(OFS_CTRL_PRI, 8'h08);
		chk(guard_cycles_q, GUARD_MAX);
		$display("test clock enable done");
		// disable with everything set, then re-enable
		pulse(11'h0e2);
		i_dbg.wr(OFS_CTRL_PRI, 8'hbf);
		i_dbg.wr(OFS_RESET_REQ, RESET_KEY);
		i_dbg.wr(OFS_CTRL_SEC, 8'h1c);
		chk({6'h0, port_reset_q, port_clk_req_q}, 8'h02);
		chk({7'h0, sys_reset_q}, 8'h00);
		i_dbg.rd(OFS_CTRL_PRI, rv, ok);
		chk({7'h0, ok}, 8'h00);
		pulse(11'h400);
		chk({7'h0, port_clk_req_q}, 8'h01);
		for (int i = 0; i < 4; i++) rchk(zl[i], 8'h00);
		rchk(OFS_CLOCK_CTRL, {6'h0, CLK_SEL_4M});
		$display("test disable done");
		// mid-run reset drops keys, held system reset and clock choice
		pulse(11'h0e0);
		i_dbg.wr(OFS_CLOCK_CTRL, 8'h01);
		i_dbg.wr(OFS_RESET_REQ, RESET_KEY);
		srst = 1'b1;
		repeat (2) @(negedge core_clk);
		srst = 1'b0;
		chk({6'h0, sys_reset_q, port_clk_req_q}, 8'h01);
		rchk(OFS_KEY_STATUS, 8'h00);
		rchk(OFS_CLOCK_CTRL, {6'h0, CLK_SEL_4M});
		$display("test mid-run reset done");
		finish_test();
	end
endmodule // tb
